// ### logic/ckec_axil.sv
// Purpose: axi4-lite slave front end, one write and one read at a time
// Assumes: 32-bit data, aligned words
// Notes: address and data of a write are taken in either order
`timescale 1ns/10ps
module ckec_axil (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_pulse,
	output logic [11:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic [11:0] rd_addr,
	output logic rd_pulse,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);
	import ckec_pkg::*;

	logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [11:0] awa_q, awa_d, ara_q, ara_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0] ws_q, ws_d;
	logic go_w, go_r;
	logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;

	// hold each write half until both have arrived
	always_comb begin
		aw_d = aw_q;
		w_d = w_q;
		b_d = b_q;
		bresp_d = bresp_q;
		awa_d = awa_q;
		wd_d = wd_q;
		ws_d = ws_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		go_w = aw_q && w_q;
		if (go_w) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			b_d = 1'b1;
			bresp_d = wr_err ? CKEC_RESP_SLVERR : CKEC_RESP_OKAY;
		end
		if (b_q && s_axi_bready) begin
			b_d = 1'b0;
		end
		// readies registered so the top's outputs come straight from flops
		awrdy_d = !aw_d && !b_d;
		wrdy_d = !w_d && !b_d;
	end

	// read: latch address, look it up the next cycle, answer the cycle after
	always_comb begin
		r_d = r_q;
		rresp_d = rresp_q;
		ara_d = ara_q;
		rd_d = rd_q;
		go_r = s_axi_arvalid && s_axi_arready;
		if (go_r) begin
			ara_d = s_axi_araddr;
		end
		if (r_q && s_axi_rready) begin
			r_d = 1'b0;
		end
		if (rd_pulse) begin
			r_d = 1'b1;
			rd_d = rd_data;
			rresp_d = rd_err ? CKEC_RESP_SLVERR : CKEC_RESP_OKAY;
		end
		// refuse a new address while one is latched or answered
		arrdy_d = !r_d && !go_r;
	end

	logic rp_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			b_q <= 1'b0;
			r_q <= 1'b0;
			rp_q <= 1'b0;
			awrdy_q <= 1'b0;
			wrdy_q <= 1'b0;
			arrdy_q <= 1'b0;
			bresp_q <= CKEC_RESP_OKAY;
			rresp_q <= CKEC_RESP_OKAY;
			awa_q <= 12'h000;
			ara_q <= 12'h000;
			wd_q <= 32'h00000000;
			rd_q <= 32'h00000000;
			ws_q <= 4'h0;
		end else begin
			aw_q <= aw_d;
			w_q <= w_d;
			b_q <= b_d;
			r_q <= r_d;
			rp_q <= go_r;
			awrdy_q <= awrdy_d;
			wrdy_q <= wrdy_d;
			arrdy_q <= arrdy_d;
			bresp_q <= bresp_d;
			rresp_q <= rresp_d;
			awa_q <= awa_d;
			ara_q <= ara_d;
			wd_q <= wd_d;
			rd_q <= rd_d;
			ws_q <= ws_d;
		end
	end

	// ready only while nothing of that kind is pending; low in reset
	assign s_axi_awready = awrdy_q;
	assign s_axi_wready = wrdy_q;
	assign s_axi_arready = arrdy_q;
	assign s_axi_bvalid = b_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = r_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rd_q;
	assign wr_pulse = go_w;
	assign wr_addr = awa_q;
	assign wr_data = wd_q;
	assign wr_strb = ws_q;
	assign rd_addr = ara_q;
	assign rd_pulse = rp_q;
endmodule

// ### logic/ckec_pkg.sv
// Purpose: shared constants and types for the cke power-down / self-refresh control block
// Assumes: 32-bit axi4-lite register bus, one channel, four ranks
// Notes: field positions follow the channel clock enable control word
package ckec_pkg;
	localparam int unsigned CKEC_ADDR_W = 12;
	localparam int unsigned CKEC_RANKS = 4;
	// register byte offsets
	localparam logic [11:0] CKEC_CTRL_OFS = 12'h660;
	localparam logic [11:0] CKEC_STAT_OFS = 12'h664;
	localparam logic [11:0] CKEC_LOCK_OFS = 12'h668;
	localparam logic [11:0] CKEC_CMD_OFS = 12'h66C;
	localparam logic [31:0] CKEC_CTRL_RST = 32'h00000800;
	// control word field positions
	localparam int unsigned CKEC_SRX_BIT = 27;
	localparam int unsigned CKEC_HIW_LSB = 24;
	localparam int unsigned CKEC_RANK_LSB = 20;
	localparam int unsigned CKEC_LOW_LSB = 17;
	localparam int unsigned CKEC_PDN_BIT = 16;
	localparam int unsigned CKEC_TXP_LSB = 10;
	localparam int unsigned CKEC_SRW_LSB = 1;
	localparam int unsigned CKEC_SGL_BIT = 0;
	// writable bits of the control word; reserved bits read zero
	localparam logic [31:0] CKEC_CTRL_WMASK = 32'h0FFF3FFF;
	localparam logic [31:0] CKEC_RANK_MASK = 32'h00F00000;
	// slave responses
	localparam logic [1:0] CKEC_RESP_OKAY = 2'h0;
	localparam logic [1:0] CKEC_RESP_SLVERR = 2'h2;

	// per-rank cke sequencer states, one bit apart in listed order; each return to CKEC_ST_UP from CKEC_ST_XP or CKEC_ST_XS flips two bits
	typedef enum logic [2:0] {
		CKEC_ST_UP = 3'b000,
		CKEC_ST_PDN = 3'b001,
		CKEC_ST_XP = 3'b011,
		CKEC_ST_SR = 3'b010,
		CKEC_ST_XS = 3'b110
	} ckec_state_t;

	// settings decoded from the control word
	typedef struct packed {
		logic srx_req;
		logic [2:0] hi_width;
		logic [3:0] rank_inst;
		logic [2:0] lo_width;
		logic pdn_en;
		logic [3:0] txp;
		logic [8:0] srx_wait;
		logic single;
	} ckec_cfg_t;

	// commands from the scheduler
	typedef struct packed {
		logic pdn_enter;
		logic pdn_exit;
		logic sr_enter;
	} ckec_cmd_t;

	function automatic ckec_cfg_t ckec_unpack(input logic [31:0] w);
		ckec_cfg_t c;
		c.srx_req = w[CKEC_SRX_BIT];
		c.hi_width = w[CKEC_HIW_LSB +: 3];
		c.rank_inst = w[CKEC_RANK_LSB +: 4];
		c.lo_width = w[CKEC_LOW_LSB +: 3];
		c.pdn_en = w[CKEC_PDN_BIT];
		c.txp = w[CKEC_TXP_LSB +: 4];
		c.srx_wait = w[CKEC_SRW_LSB +: 9];
		c.single = w[CKEC_SGL_BIT];
		return c;
	endfunction
endpackage

// ### logic/ckec_rank.sv
// Purpose: cke sequencer for one rank
// Assumes: settings stable while a transition is in progress
// Notes: counts separate down-counters for the width and for the exit waits
`timescale 1ns/10ps
module ckec_rank (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic installed,
	input wire ckec_pkg::ckec_cfg_t cfg,
	input wire ckec_pkg::ckec_cmd_t cmd,
	input wire logic srx_go,
	output logic cke,
	output logic cmd_ok,
	output logic read_ok,
	output logic in_sr
);
	import ckec_pkg::*;

	ckec_state_t st_q, st_d;
	logic [8:0] wid_q, wid_d;
	logic [8:0] wait_q, wait_d;

	// next state; width counter guards every cke edge
	always_comb begin
		st_d = st_q;
		wid_d = (wid_q != 9'h000) ? wid_q - 9'h001 : wid_q;
		wait_d = (wait_q != 9'h000) ? wait_q - 9'h001 : wait_q;
		case (st_q)
			CKEC_ST_UP: begin
				if (installed && wid_q == 9'h000) begin
					if (cmd.pdn_enter && cfg.pdn_en) begin
						st_d = CKEC_ST_PDN;
						wid_d = {6'h00, cfg.lo_width};
					end else if (cmd.sr_enter) begin
						st_d = CKEC_ST_SR;
						wid_d = {6'h00, cfg.lo_width};
					end
				end
			end
			CKEC_ST_PDN: begin
				if (wid_q == 9'h000 && (cmd.pdn_exit || !cfg.pdn_en)) begin
					st_d = CKEC_ST_XP;
					wid_d = {6'h00, cfg.hi_width};
					wait_d = {5'h00, cfg.txp};
				end
			end
			CKEC_ST_XP: begin
				if (wait_q <= 9'h001) begin
					st_d = CKEC_ST_UP;
				end
			end
			CKEC_ST_SR: begin
				if (wid_q == 9'h000 && srx_go) begin
					st_d = CKEC_ST_XS;
					wid_d = {6'h00, cfg.hi_width};
					wait_d = cfg.srx_wait;
				end
			end
			CKEC_ST_XS: begin
				if (wait_q <= 9'h001) begin
					st_d = CKEC_ST_UP;
				end
			end
			default: begin
				st_d = CKEC_ST_UP;
			end
		endcase
		if (!installed) begin
			st_d = CKEC_ST_UP;
		end
	end

	// registers; the outputs below are decoded from them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= CKEC_ST_UP;
			wid_q <= 9'h000;
			wait_q <= 9'h000;
		end else begin
			st_q <= st_d;
			wid_q <= wid_d;
			wait_q <= wait_d;
		end
	end

	assign cke = installed && (st_q != CKEC_ST_PDN) && (st_q != CKEC_ST_SR);
	assign cmd_ok = installed && (st_q == CKEC_ST_UP);
	assign read_ok = installed && (st_q == CKEC_ST_UP || st_q == CKEC_ST_XP);
	assign in_sr = (st_q == CKEC_ST_SR);
endmodule

// ### logic/ckec_top.sv
// Purpose: cke power-down and self-refresh control for one memory channel
// Assumes: scheduler presents power-down and self-refresh requests; aclk is the command clock
// Notes: four ranks, each with its own cke sequencer; registers over axi4-lite
// Contract
// - setting the self-refresh exit request starts the exit sequence out of self-refresh.
// - after cke rises it stays high for at least the high-phase width in clocks.
// - after cke falls it stays low for at least the low-phase width in clocks.
// - each of four rank flags reads one when the rank is installed and zero when absent.
// - once the stolen-memory lock is set, writes leave the rank flags unchanged.
// - cke toggles for power-down only while the power-down toggle enable is set.
// - after a power-down exit no non-read command goes out before the programmed spacing.
// - after self-refresh exit, restricted commands wait the nine-bit exit count.
// - the single-module flag tells the controller only one module is fitted.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module ckec_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic stolen_mem_lock,
	input wire logic [3:0] pdn_enter,
	input wire logic [3:0] pdn_exit,
	input wire logic [3:0] sr_enter,
	output logic [3:0] cke,
	output logic [3:0] cmd_allowed,
	output logic [3:0] read_allowed,
	output logic single_module
);
	import ckec_pkg::*;

	logic [31:0] ctrl_q, ctrl_d;
	logic lock_q, lock_d;
	logic [3:0] cke_q, cmd_q, rd_q;
	logic sgl_q;
	logic [3:0] cke_w, cmd_w, rdok_w, insr_w;
	logic wr_pulse, rd_pulse, wr_err, rd_err;
	logic [11:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	ckec_cfg_t cfg;
	logic srx_go;

	// ---------------------------------------------
	// register bus
	// ---------------------------------------------
	ckec_axil u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_pulse(wr_pulse),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_pulse(rd_pulse),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// byte-lane merge of a write into a word
	function automatic logic [31:0] ckec_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	assign wr_err = !(wr_addr == CKEC_CTRL_OFS || wr_addr == CKEC_LOCK_OFS ||
		wr_addr == CKEC_STAT_OFS);
	assign rd_err = !(rd_addr == CKEC_CTRL_OFS || rd_addr == CKEC_LOCK_OFS ||
		rd_addr == CKEC_STAT_OFS);

	// ---------------------------------------------
	// control word and lock
	// ---------------------------------------------
	// the exit request self-clears once every sequencer in self-refresh has seen it
	always_comb begin
		logic [31:0] m;
		m = ckec_merge(ctrl_q, wr_data, wr_strb) & CKEC_CTRL_WMASK;
		ctrl_d = ctrl_q;
		lock_d = lock_q | stolen_mem_lock;
		if (srx_go && insr_w == 4'h0) begin
			ctrl_d[CKEC_SRX_BIT] = 1'b0;
		end
		if (wr_pulse && wr_addr == CKEC_CTRL_OFS) begin
			// locked rank flags keep their value
			if (lock_q) begin
				m = (m & ~CKEC_RANK_MASK) | (ctrl_q & CKEC_RANK_MASK);
			end
			// software set wins over the self-clear
			ctrl_d = m;
		end
		if (wr_pulse && wr_addr == CKEC_LOCK_OFS && wr_strb[0] && wr_data[0]) begin
			lock_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CKEC_CTRL_RST;
			lock_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			lock_q <= lock_d;
		end
	end

	// read mux: control, status (cke, in self-refresh, read allowed), lock
	always_comb begin
		rd_data = 32'h00000000;
		case (rd_addr)
			CKEC_CTRL_OFS: rd_data = ctrl_q;
			CKEC_STAT_OFS: rd_data = {20'h00000, rd_q, insr_w, cke_q};
			CKEC_LOCK_OFS: rd_data = {31'h00000000, lock_q};
			default: rd_data = 32'h00000000;
		endcase
	end

	// ---------------------------------------------
	// per-rank cke sequencers
	// ---------------------------------------------
	assign cfg = ckec_unpack(ctrl_q);
	assign srx_go = cfg.srx_req;

	for (genvar g = 0; g < CKEC_RANKS; g++) begin : g_rank
		ckec_cmd_t c;
		assign c = '{pdn_enter: pdn_enter[g], pdn_exit: pdn_exit[g], sr_enter: sr_enter[g]};
		ckec_rank u_rank (
			.aclk(aclk),
			.aresetn(aresetn),
			.installed(cfg.rank_inst[g]),
			.cfg(cfg),
			.cmd(c),
			.srx_go(srx_go),
			.cke(cke_w[g]),
			.cmd_ok(cmd_w[g]),
			.read_ok(rdok_w[g]),
			.in_sr(insr_w[g])
		);
	end

	// ---------------------------------------------
	// registered outputs
	// ---------------------------------------------
	// single-module flag to the scheduler
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cke_q <= 4'h0;
			cmd_q <= 4'h0;
			rd_q <= 4'h0;
			sgl_q <= 1'b0;
		end else begin
			cke_q <= cke_w;
			cmd_q <= cmd_w;
			rd_q <= rdok_w;
			sgl_q <= cfg.single;
		end
	end

	assign cke = cke_q;
	assign cmd_allowed = cmd_q;
	assign read_allowed = rd_q;
	assign single_module = sgl_q;
endmodule

// ### sim/ckec_assertions.sv
// Purpose: port-level checker for the cke sequencing of rank 0 and 3
// Assumes: full-word writes, lock raised from the pin or the lock register
// Notes: shadows the control word, one cycle late, to know the widths
`timescale 1ns/10ps
module ckec_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic stolen_mem_lock,
	input wire logic [3:0] sr_enter,
	input wire logic [3:0] cke,
	input wire logic [3:0] cmd_allowed,
	input wire logic [3:0] read_allowed,
	input wire logic single_module
);
	import ckec_pkg::*;
	logic [11:0] wa_q;
	logic [31:0] wd_q;
	logic [31:0] cw_q;
	logic [3:0] rk_q;
	logic lk_q;
	logic [7:0] run_q;
	// ----
	// shadow state
	// ----
	// run_q saturates so long waits never wrap into a false short run
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cw_q <= CKEC_CTRL_RST;
			rk_q <= 4'h0;
			lk_q <= 1'b0;
			run_q <= 8'h00;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				wa_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
				wd_q <= s_axi_wdata;
			if ($rose(s_axi_bvalid) && wa_q == CKEC_CTRL_OFS)
				cw_q <= wd_q;
			if ($rose(s_axi_bvalid) && wa_q == CKEC_CTRL_OFS && !lk_q)
				rk_q <= wd_q[23:20];
			lk_q <= lk_q | stolen_mem_lock | ($rose(s_axi_bvalid) && wa_q == CKEC_LOCK_OFS && wd_q[0]);
			run_q <= (cke[0] != $past(cke[0])) ? 8'h01 : run_q + {7'h00, run_q != 8'hFF};
		end
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_high_hold: assert property ($fell(cke[0]) |-> run_q >= cw_q[26:24])
		else $error("cke high phase too short");
	chk_low_hold: assert property ($rose(cke[0]) |-> run_q >= cw_q[19:17])
		else $error("cke low phase too short");
	chk_pdn_gate: assert property ($fell(cke[0]) && !$past(sr_enter[0]) |-> cw_q[16])
		else $error("cke dropped with toggle disabled");
	chk_txp_space: assert property ($rose(cmd_allowed[0]) && $past(read_allowed[0])
		|-> run_q >= cw_q[13:10])
		else $error("command too soon after power-down exit");
	chk_srx_wait: assert property ($rose(cmd_allowed[0]) && !$past(read_allowed[0])
		|-> run_q >= cw_q[9:1])
		else $error("command too soon after self-refresh exit");
	chk_srx_start: assert property ($rose(s_axi_bvalid) && wa_q == CKEC_CTRL_OFS
		&& wd_q[27] && !cke[0] |-> ##[0:4] cke[0])
		else $error("self-refresh exit did not start");
	chk_single_flag: assert property ($rose(s_axi_bvalid) && wa_q == CKEC_CTRL_OFS
		|-> ##[0:2] single_module == wd_q[0])
		else $error("single module flag wrong");
	chk_absent_quiet: assert property (!rk_q[3] |-> !cke[3] && !cmd_allowed[3])
		else $error("absent rank driven");
	cover property ($fell(cke[0]) && cw_q[16]);
	cover property ($rose(cmd_allowed[0]) && !$past(read_allowed[0]) && cw_q[9:1] != 9'h000);
	cover property (lk_q && $rose(s_axi_bvalid));
endmodule

bind ckec_top ckec_assertions u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.stolen_mem_lock, .sr_enter, .cke, .cmd_allowed, .read_allowed, .single_module);

// ### sim/ckec_dram_model.sv
// Purpose: far-side rank monitor for the memory channel
// Assumes: one cke line per rank, no command bus modelled
// Notes: the ranks drive nothing back, so the model only records edges
`timescale 1ns/10ps
module ckec_dram_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] cke,
	output logic [3:0] woke,
	output logic [3:0] slept
);
	logic [3:0] cke_q;
	// ----
	// edge capture
	// ----
	// absent ranks quiet: sticky, so a single glitch is never missed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cke_q <= 4'h0;
			woke <= 4'h0;
			slept <= 4'h0;
		end else begin
			cke_q <= cke;
			woke <= woke | (cke & ~cke_q);
			slept <= slept | (~cke & cke_q);
		end
	end
endmodule

// ### sim/tb_ckec_top.sv
// Purpose: self-checking bench for the cke control block
// Assumes: full-word writes, lock from the pin, then from the register after a mid-run reset
// Notes: ranks 0 and 2 installed; ranks 1 and 3 stay absent
`timescale 1ns/10ps
module tb_ckec_top;
	import ckec_pkg::*;
	// hi 7, ranks 0101, lo 4, txp 5, srx 255, single module
	localparam logic [31:0] CFG = 32'h075815FF;
	localparam logic [31:0] PDN = 32'h075915FF;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, stolen_mem_lock, single_module;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, pdn_enter, pdn_exit, sr_enter, cke, cmd_allowed, read_allowed;
	logic [3:0] woke, slept;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int err_total, samples_checked;
	ckec_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stolen_mem_lock,
		.pdn_enter, .pdn_exit, .sr_enter, .cke, .cmd_allowed, .read_allowed, .single_module);
	ckec_dram_model dram (.aclk, .aresetn, .cke, .woke, .slept);
	// ----
	// helpers
	// ----
	task automatic bad(input string m);
		err_total++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e)
			bad(m);
	endtask
	// both channels offered together, each dropped at its own handshake
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_awvalid)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid)
				s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
		cmp(s_axi_bresp, CKEC_RESP_OKAY, "write refused");
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready && s_axi_arvalid)
				s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
		cmp(s_axi_rresp, r, "read response");
		if (r === CKEC_RESP_OKAY)
			cmp(s_axi_rdata, e, "read data");
	endtask
	// edges until rank 0 {cmd, cke} under mask matches, capped at 400
	task automatic till(input logic [1:0] k, input logic [1:0] v, output int c);
		c = 0;
		while ((({cmd_allowed[0], cke[0]} & k) !== v) && c < 400) begin
			@(posedge aclk);
			c++;
		end
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset;
		rd(CKEC_CTRL_OFS, CKEC_CTRL_RST, CKEC_RESP_OKAY);
		rd(CKEC_STAT_OFS, 32'h00000000, CKEC_RESP_OKAY);
		rd(12'h700, 32'h00000000, CKEC_RESP_SLVERR);
	endtask
	task automatic t_install;
		wr(CKEC_CTRL_OFS, 32'h00500800);
		repeat (4) @(posedge aclk);
		cmp({cke, cmd_allowed, read_allowed}, 12'h555, "install");
	endtask
	task automatic t_pdn;
		int n;
		int m;
		wr(CKEC_CTRL_OFS, CFG);
		repeat (2) @(posedge aclk);
		cmp(single_module, 1'b1, "single module");
		pdn_enter <= 4'hF;
		repeat (10) @(posedge aclk);
		cmp(cke, 4'h5, "toggled while disabled");
		wr(CKEC_CTRL_OFS, PDN);
		till(2'b01, 2'b00, n);
		cmp(cke, 4'h0, "no power-down");
		pdn_enter <= 4'h0;
		pdn_exit <= 4'hF;
		till(2'b01, 2'b01, n);
		cmp(n >= 4 && n <= 8, 1'b1, "low width");
		cmp(read_allowed[0], 1'b1, "read during spacing");
		till(2'b10, 2'b10, m);
		cmp(m >= 5 && m <= 8, 1'b1, "exit spacing");
		pdn_exit <= 4'h0;
		pdn_enter <= 4'hF;
		till(2'b01, 2'b00, n);
		cmp(m + n >= 7 && m + n <= 11, 1'b1, "high width");
		pdn_enter <= 4'h0;
		pdn_exit <= 4'hF;
		till(2'b11, 2'b11, n);
		pdn_exit <= 4'h0;
		cmp(cke, 4'h5, "back up");
	endtask
	task automatic t_sr;
		int n;
		sr_enter <= 4'h5;
		till(2'b01, 2'b00, n);
		sr_enter <= 4'h0;
		rd(CKEC_STAT_OFS, 32'h00000050, CKEC_RESP_OKAY);
		wr(CKEC_CTRL_OFS, PDN | 32'h08000000);
		till(2'b01, 2'b01, n);
		cmp(n <= 6, 1'b1, "exit not started");
		till(2'b10, 2'b10, n);
		cmp(n >= 255 && n <= 262, 1'b1, "exit wait");
		rd(CKEC_CTRL_OFS, PDN, CKEC_RESP_OKAY);
	endtask
	task automatic t_lock;
		stolen_mem_lock <= 1'b1;
		repeat (2) @(posedge aclk);
		wr(CKEC_CTRL_OFS, PDN | 32'h00F00000);
		rd(CKEC_CTRL_OFS, PDN, CKEC_RESP_OKAY);
		cmp(cke, 4'h5, "locked ranks moved");
		cmp({slept, woke}, 8'h55, "absent rank toggled");
	endtask
	// mid-run reset, then lock taken through the lock register
	task automatic t_swlock;
		stolen_mem_lock <= 1'b0;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CKEC_LOCK_OFS, 32'h00000000, CKEC_RESP_OKAY);
		wr(CKEC_LOCK_OFS, 32'h00000001);
		rd(CKEC_LOCK_OFS, 32'h00000001, CKEC_RESP_OKAY);
		wr(CKEC_CTRL_OFS, 32'h00F00800);
		rd(CKEC_CTRL_OFS, CKEC_CTRL_RST, CKEC_RESP_OKAY);
		cmp(cke, 4'h0, "locked ranks moved");
		cmp(single_module, 1'b0, "single flag after reset");
	endtask
	task automatic final_report;
		if (err_total == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----
	// clock, watchdog, sequence
	// ----
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// the whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		bad("timeout");
		final_report;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
		{s_axi_rready, stolen_mem_lock, pdn_enter, pdn_exit, sr_enter} = 14'h0000;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hF;
		err_total = 0;
		samples_checked = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_install;
		t_pdn;
		t_sr;
		t_lock;
		t_swlock;
		final_report;
	end
endmodule
